// ---- bridge_gate_pkg.sv ----
// constants and carrier types for the three-phase bridge gate logic
// assumes a single 200 MHz system clock shared by every user of the package
package bridge_gate_pkg;

  // system clock
  localparam int unsigned CLK_MHZ          = 200;

  // dead time: one count step in ns, and the step in clock cycles (least time, rounded up)
  localparam int unsigned DT_STEP_NS       = 50;
  localparam int unsigned DT_STEP_CYC_INT  = (DT_STEP_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned DT_CNT_W         = 10;
  localparam logic [DT_CNT_W-1:0] DT_STEP_CYC = DT_CNT_W'(DT_STEP_CYC_INT);

  // counts below this are raised to it, giving the 100 ns floor
  localparam logic [5:0] DT_MIN_COUNT      = 6'h02;

  // zero-crossing filter length in samples, default only
  localparam int unsigned ZC_FILT_LEN      = 4;

  // number of bridge phases and index of the last commutation state
  localparam int unsigned PHASES           = 3;
  localparam logic [2:0] COMM_LAST         = 3'h5;

  // off-time recirculation selector
  typedef enum logic [1:0] {
    RECIRC_AUTO    = 2'b00,
    RECIRC_HIGH    = 2'b01,
    RECIRC_LOW     = 2'b10,
    RECIRC_NONSYNC = 2'b11
  } recirc_mode_t;

  localparam recirc_mode_t RECIRC_RESET    = RECIRC_AUTO;

  // per-phase switch command, 1 = switch conducting
  typedef struct packed {
    logic hi;
    logic lo;
  } gate_cmd_t;

  localparam gate_cmd_t GATE_ALL_OFF       = '{hi: 1'b0, lo: 1'b0};

endpackage

// ---- bridge_gate_deadtime_recirc.sv ----
// three-phase bridge gate commands with dead time and off-time recirculation choice
// assumes all inputs are synchronous to ref_clk_i and that the commutation logic
// pulses comm_start_i once at the start of each commutation period
//
// Behaviour
// - low-side gate output goes high when its switch is commanded on.
// - low-side gate output goes low when its switch is commanded off.
// - high-side gate output goes low when its switch is commanded on.
// - high-side gate output goes high when its switch is commanded off.
// - after any turn-off, wait the dead time before the complementary turn-on.
// - one six-bit dead-time count serves all phases, timed from the clock.
// - dead time equals the count times 50 ns.
// - counts zero, one and two all give the 100 ns minimum.
// - synchronous modes switch the PWM phase pair in anti-phase with dead time.
// - selector 11 turns every switch off during PWM off-time.
// - selector 10 recirculates through the low-side switches during off-time.
// - selector 01 recirculates through the high-side switches during off-time.
// - mixed mode, falling bemf: low-side before zero crossing, high-side after.
// - mixed mode, rising bemf: high-side before zero crossing, low-side after.
// - the zero-crossing comparator output is digitally filtered before use.
// - the recirculation selector comes out of reset as 00, mixed mode.
`timescale 1ns/1ps

module phase_deadtime
  import bridge_gate_pkg::*;
(
  // clock and reset
  input  wire logic                ref_clk_i,
  input  wire logic                arst_n_i,
  // wanted switch state and dead time in cycles
  input  wire gate_cmd_t           want_i,
  input  wire logic [DT_CNT_W-1:0] dt_cycles_i,
  // switch state actually applied
  output gate_cmd_t                gate_o
);

  gate_cmd_t           on_ff;
  gate_cmd_t           nxt_on;
  logic [DT_CNT_W-1:0] cnt_ff;
  logic [DT_CNT_W-1:0] nxt_cnt;
  logic                turn_off;

  always_comb
  begin
    turn_off  = (on_ff.hi & ~want_i.hi) | (on_ff.lo & ~want_i.lo);
    // turn-off is immediate; only turn-on is delayed
    nxt_on.hi = on_ff.hi & want_i.hi;
    nxt_on.lo = on_ff.lo & want_i.lo;
    nxt_cnt   = cnt_ff;
    if (turn_off)
    begin
      // load one less, the turn-on itself takes the last cycle
      nxt_cnt = dt_cycles_i - DT_CNT_W'(1);
    end
    else
    begin
      if (cnt_ff != '0)
      begin
        nxt_cnt = cnt_ff - DT_CNT_W'(1);
      end
      // a conflicting request of both switches turns neither on
      if (cnt_ff == '0 && want_i.hi && !want_i.lo && !on_ff.lo)
      begin
        nxt_on.hi = 1'b1;
      end
      if (cnt_ff == '0 && want_i.lo && !want_i.hi && !on_ff.hi)
      begin
        nxt_on.lo = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      on_ff  <= GATE_ALL_OFF;
      cnt_ff <= '0;
    end
    else
    begin
      on_ff  <= nxt_on;
      cnt_ff <= nxt_cnt;
    end
  end

  assign gate_o = on_ff;

endmodule

module bridge_gate_deadtime_recirc
  import bridge_gate_pkg::*;
#(
  parameter int unsigned FILT_LEN = ZC_FILT_LEN
)
(
  // clock and reset
  input  wire logic         ref_clk_i,
  input  wire logic         arst_n_i,
  // bridge control
  input  wire logic         drive_en_i,
  input  wire logic         bridge_pwm_i,
  input  wire logic [2:0]   comm_state_i,
  input  wire logic         comm_start_i,
  input  wire logic         bemf_falling_i,
  input  wire logic         zc_cmp_i,
  // configuration
  input  wire logic [5:0]   dead_time_count_i,
  input  wire logic [1:0]   recirc_mode_sel_i,
  // gate outputs
  output logic [PHASES-1:0] low_side_gate_out_o,
  output logic [PHASES-1:0] high_side_gate_out_n_o,
  // status
  output logic              zc_level_o,
  output logic              zc_strobe_o,
  output logic              recirc_high_o
);

  // ---- configuration capture ----
  recirc_mode_t        mode_ff;
  recirc_mode_t        nxt_mode;
  logic [5:0]          dt_eff;
  logic [DT_CNT_W-1:0] dt_cycles;

  always_comb
  begin
    nxt_mode  = recirc_mode_t'(recirc_mode_sel_i);
    dt_eff    = (dead_time_count_i < DT_MIN_COUNT) ? DT_MIN_COUNT : dead_time_count_i;
    // widest result is 63 steps of 10 cycles, well inside the counter
    dt_cycles = DT_CNT_W'(DT_CNT_W'(dt_eff) * DT_STEP_CYC);
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      mode_ff <= RECIRC_RESET;
    end
    else
    begin
      mode_ff <= nxt_mode;
    end
  end

  // ---- zero-crossing filter ----
  // the level only moves once FILT_LEN samples in a row agree; this trades
  // FILT_LEN + 1 cycles of delay for immunity to comparator chatter
  logic [FILT_LEN-1:0] zc_hist_ff;
  logic [FILT_LEN-1:0] nxt_zc_hist;
  logic                zc_lvl_ff;
  logic                nxt_zc_lvl;
  logic                zc_stb_ff;
  logic                nxt_zc_stb;

  always_comb
  begin
    nxt_zc_hist = {zc_hist_ff[FILT_LEN-2:0], zc_cmp_i};
    nxt_zc_lvl  = zc_lvl_ff;
    if (&zc_hist_ff)
    begin
      nxt_zc_lvl = 1'b1;
    end
    else if (~|zc_hist_ff)
    begin
      nxt_zc_lvl = 1'b0;
    end
    nxt_zc_stb  = nxt_zc_lvl ^ zc_lvl_ff;
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      zc_hist_ff <= '0;
      zc_lvl_ff  <= 1'b0;
      zc_stb_ff  <= 1'b0;
    end
    else
    begin
      zc_hist_ff <= nxt_zc_hist;
      zc_lvl_ff  <= nxt_zc_lvl;
      zc_stb_ff  <= nxt_zc_stb;
    end
  end

  // ---- mixed-mode path tracking ----
  logic after_zc_ff;
  logic nxt_after_zc;
  logic path_hi_ff;
  logic nxt_path_hi;
  logic want_path_hi;

  always_comb
  begin
    nxt_after_zc = after_zc_ff;
    if (comm_start_i)
    begin
      nxt_after_zc = 1'b0;
    end
    // a crossing in the same cycle as a new period is kept
    if (zc_stb_ff)
    begin
      nxt_after_zc = 1'b1;
    end
    case (mode_ff)
      RECIRC_HIGH:    want_path_hi = 1'b1;
      RECIRC_LOW:     want_path_hi = 1'b0;
      RECIRC_AUTO:    want_path_hi = bemf_falling_i ? after_zc_ff : ~after_zc_ff;
      default:        want_path_hi = 1'b0;
    endcase
    // the path is frozen for the whole off-time, so a change waits for the next one
    nxt_path_hi = bridge_pwm_i ? want_path_hi : path_hi_ff;
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      after_zc_ff <= 1'b0;
      path_hi_ff  <= 1'b0;
    end
    else
    begin
      after_zc_ff <= nxt_after_zc;
      path_hi_ff  <= nxt_path_hi;
    end
  end

  // ---- wanted switch states per phase ----
  logic [1:0] src_ph;
  logic [1:0] snk_ph;
  logic       comm_ok;
  gate_cmd_t  want [PHASES];

  always_comb
  begin
    comm_ok = drive_en_i && (comm_state_i <= COMM_LAST);
    // drive-high phase and drive-low phase of each commutation state
    case (comm_state_i)
      3'h0:    begin src_ph = 2'h0; snk_ph = 2'h1; end
      3'h1:    begin src_ph = 2'h0; snk_ph = 2'h2; end
      3'h2:    begin src_ph = 2'h1; snk_ph = 2'h2; end
      3'h3:    begin src_ph = 2'h1; snk_ph = 2'h0; end
      3'h4:    begin src_ph = 2'h2; snk_ph = 2'h0; end
      3'h5:    begin src_ph = 2'h2; snk_ph = 2'h1; end
      default: begin src_ph = 2'h0; snk_ph = 2'h0; end
    endcase
    for (int p = 0; p < PHASES; p++)
    begin
      want[p] = GATE_ALL_OFF;
      if (comm_ok && bridge_pwm_i)
      begin
        want[p].hi = (2'(p) == src_ph);
        want[p].lo = (2'(p) == snk_ph);
      end
      else if (comm_ok && mode_ff != RECIRC_NONSYNC)
      begin
        if (path_hi_ff)
        begin
          // both active phases held at the supply
          want[p].hi = (2'(p) == src_ph) || (2'(p) == snk_ph);
        end
        else
        begin
          // both active phases held at ground
          want[p].lo = (2'(p) == src_ph) || (2'(p) == snk_ph);
        end
      end
    end
  end

  // ---- dead-time sequencing and pin polarity ----
  gate_cmd_t applied [PHASES];

  for (genvar g = 0; g < PHASES; g++)
  begin : g_phase
    phase_deadtime u_dt (
      .ref_clk_i   (ref_clk_i),
      .arst_n_i    (arst_n_i),
      .want_i      (want[g]),
      .dt_cycles_i (dt_cycles),
      .gate_o      (applied[g])
    );
    assign low_side_gate_out_o[g]    = applied[g].lo;
    assign high_side_gate_out_n_o[g] = ~applied[g].hi;
  end

  assign zc_level_o    = zc_lvl_ff;
  assign zc_strobe_o   = zc_stb_ff;
  assign recirc_high_o = path_hi_ff;

endmodule

// ---- bridge_gate_deadtime_recirc_asserts.sv ----
// port assertions for the bridge gate block
// assumes binding onto every instance of the block
`timescale 1ns/1ps
module bridge_gate_deadtime_recirc_asserts
  import bridge_gate_pkg::*;
#(
  parameter int unsigned FILT_LEN = ZC_FILT_LEN
)
(
  // clock and reset
  input wire logic              ref_clk_i,
  input wire logic              arst_n_i,
  // inputs watched
  input wire logic              bridge_pwm_i,
  input wire logic              zc_cmp_i,
  input wire logic [1:0]        recirc_mode_sel_i,
  // outputs watched
  input wire logic [PHASES-1:0] low_side_gate_out_o,
  input wire logic [PHASES-1:0] high_side_gate_out_n_o,
  input wire logic              zc_level_o,
  input wire logic              zc_strobe_o,
  input wire logic              recirc_high_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!arst_n_i);
  AST_NO_SHOOT: assert property ((low_side_gate_out_o & ~high_side_gate_out_n_o) == 3'h0)
    else $error("both switches of a phase on");
  AST_LO_OFF_DEAD: assert property ($fell(low_side_gate_out_o[0]) |=> high_side_gate_out_n_o[0] [*8])
    else $error("high side on too soon");
  AST_HI_OFF_DEAD: assert property ($rose(high_side_gate_out_n_o[0]) |=> (!low_side_gate_out_o[0]) [*8])
    else $error("low side on too soon");
  AST_NONSYNC_OFF: assert property ((recirc_mode_sel_i == 2'b11 && !bridge_pwm_i) [*3] |->
    low_side_gate_out_o == 3'h0 && high_side_gate_out_n_o == 3'h7) else $error("switch on in fast decay");
  AST_LOW_PATH: assert property ((recirc_mode_sel_i == 2'b10 && bridge_pwm_i) [*2] ##1
    (recirc_mode_sel_i == 2'b10 && !bridge_pwm_i) [*2] |-> high_side_gate_out_n_o == 3'h7) else $error("high on");
  AST_HIGH_PATH: assert property ((recirc_mode_sel_i == 2'b01 && bridge_pwm_i) [*2] ##1
    (recirc_mode_sel_i == 2'b01 && !bridge_pwm_i) [*2] |-> low_side_gate_out_o == 3'h0) else $error("low on");
  AST_RESET_OFF: assert property ($rose(arst_n_i) |-> !recirc_high_o && low_side_gate_out_o == 3'h0)
    else $error("not idle after reset");
  AST_ZC_FILT: assert property ($changed(zc_level_o) |-> zc_level_o == $past(zc_cmp_i, 3)
    && zc_level_o == $past(zc_cmp_i, 4)) else $error("level changed without stable input");
  AST_ZC_STROBE: assert property ($changed(zc_level_o) |-> zc_strobe_o ##1 !zc_strobe_o)
    else $error("strobe not one cycle");
  AST_PATH_HOLD: assert property (!$past(bridge_pwm_i) |-> $stable(recirc_high_o))
    else $error("path changed in off-time");
endmodule

bind bridge_gate_deadtime_recirc bridge_gate_deadtime_recirc_asserts #(.FILT_LEN(FILT_LEN)) u_asserts (
  .ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .bridge_pwm_i(bridge_pwm_i), .zc_cmp_i(zc_cmp_i),
  .recirc_mode_sel_i(recirc_mode_sel_i), .low_side_gate_out_o(low_side_gate_out_o),
  .high_side_gate_out_n_o(high_side_gate_out_n_o), .zc_level_o(zc_level_o), .zc_strobe_o(zc_strobe_o),
  .recirc_high_o(recirc_high_o));

// ---- mosfet_bridge_model.sv ----
// behavioural complementary mosfet bridge driven by the gate outputs
// assumes gates settle within one system clock; latches any shoot-through
`timescale 1ns/1ps
module mosfet_bridge_model
(
  // clock
  input  wire logic       ref_clk_i,
  // gates
  input  wire logic [2:0] lo_gate_i,
  input  wire logic [2:0] hi_gate_n_i,
  // phase nodes and fault
  output logic [2:0]      phase_sense_o,
  output logic            shoot_o
);
  logic [2:0] float_q = 3'h0;
  // one procedural driver for the fault flag, cleared at time zero
  logic       shoot_q = 1'b0;
  assign shoot_o = shoot_q;
  // an undriven node must not look like a held level
  always @(posedge ref_clk_i)
  begin
    float_q <= ~phase_sense_o;
    if ((lo_gate_i & ~hi_gate_n_i) != 3'h0)
      shoot_q <= 1'b1;
  end
  always_comb
  begin
    for (int i = 0; i < 3; i++)
      phase_sense_o[i] = !hi_gate_n_i[i] ? 1'b1 : (lo_gate_i[i] ? 1'b0 : float_q[i]);
  end
endmodule

// ---- bridge_gate_deadtime_recirc_tb_top.sv ----
// self-checking bench for the bridge gate block with a bridge model
// assumes the default filter length and a 200 MHz clock
`timescale 1ns/1ps
module bridge_gate_deadtime_recirc_tb_top;
  logic       ref_clk_i, arst_n_i, drive_en_i, bridge_pwm_i, comm_start_i, bemf_falling_i, zc_cmp_i;
  logic       zc_level, zc_strobe, recirc_high, shoot;
  logic [2:0] comm_state_i, lo, hn, sense;
  logic [5:0] dead_time_count_i;
  logic [1:0] recirc_mode_sel_i;
  logic [5:0] dts [5] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h18};
  int         fail_count = 0;
  int         comparisons = 0;

  bridge_gate_deadtime_recirc u_bridge_gate_deadtime_recirc (
    .ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .drive_en_i(drive_en_i), .bridge_pwm_i(bridge_pwm_i),
    .comm_state_i(comm_state_i), .comm_start_i(comm_start_i), .bemf_falling_i(bemf_falling_i),
    .zc_cmp_i(zc_cmp_i), .dead_time_count_i(dead_time_count_i), .recirc_mode_sel_i(recirc_mode_sel_i),
    .low_side_gate_out_o(lo), .high_side_gate_out_n_o(hn), .zc_level_o(zc_level),
    .zc_strobe_o(zc_strobe), .recirc_high_o(recirc_high));
  mosfet_bridge_model u_mosfet_bridge_model (
    .ref_clk_i(ref_clk_i), .lo_gate_i(lo), .hi_gate_n_i(hn), .phase_sense_o(sense), .shoot_o(shoot));

  initial
  begin
    ref_clk_i = 1'b0;
    forever #2.5 ref_clk_i = ~ref_clk_i;
  end

  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk_i);
  endtask

  task automatic chk(input string name, input logic [9:0] exp, input logic [9:0] got);
    comparisons++;
    if (got !== exp)
    begin
      fail_count++;
      $display("MISMATCH %s expected %0h seen %0h", name, exp, got);
    end
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // one off-time in mode sel; hi picks the expected recirculation rail
  task automatic offtime(input logic [1:0] sel, input logic hi);
    recirc_mode_sel_i = sel;
    bridge_pwm_i = 1'b1;
    cyc(30);
    bridge_pwm_i = 1'b0;
    cyc(30);
    chk("off low gates", (sel == 2'b11 || hi) ? 3'h0 : 3'h3, lo);
    chk("off high gates", (sel == 2'b11 || !hi) ? 3'h7 : 3'h4, hn);
    // the applied rail means nothing in fast decay
    if (sel != 2'b11)
      chk("path rail", hi, recirc_high);
  endtask

  // on-time gates for every commutation state; states 6 and 7 drive nothing
  task automatic comm_sweep();
    logic [2:0] exp_lo [8] = '{3'h2, 3'h4, 3'h4, 3'h1, 3'h1, 3'h2, 3'h0, 3'h0};
    logic [2:0] exp_hn [8] = '{3'h6, 3'h6, 3'h5, 3'h5, 3'h3, 3'h3, 3'h7, 3'h7};
    bridge_pwm_i = 1'b1;
    for (int s = 0; s < 8; s++)
    begin
      comm_state_i = 3'(s);
      cyc(30);
      chk("state low gates", exp_lo[s], lo);
      chk("state high gates", exp_hn[s], hn);
    end
    comm_state_i = 3'h0;
    cyc(30);
  endtask

  // time from turn-off to complementary turn-on on phase a, both directions
  task automatic dead(input logic [5:0] dt);
    int n;
    dead_time_count_i = dt;
    for (int p = 0; p < 2; p++)
    begin
      n = 0;
      bridge_pwm_i = p[0];
      cyc(1);
      while ((p[0] ? hn[0] : !lo[0]) !== 1'b0 && n < 700)
      begin
        cyc(1);
        n++;
      end
      chk("dead cycles", 10'((dt < 6'h03 ? 6'h02 : dt) * 10), 10'(n));
    end
  endtask

  task automatic zc(input logic falling);
    int n;
    n = 0;
    bemf_falling_i = falling;
    comm_start_i = 1'b1;
    cyc(1);
    comm_start_i = 1'b0;
    offtime(2'b00, !falling);
    zc_cmp_i = !zc_cmp_i;
    while (zc_strobe !== 1'b1 && n < 20)
    begin
      cyc(1);
      n++;
    end
    chk("filter delay", 10'(bridge_gate_pkg::ZC_FILT_LEN + 1), 10'(n));
    chk("filtered level", zc_cmp_i, zc_level);
    offtime(2'b00, falling);
  endtask

  initial
  begin
    {arst_n_i, drive_en_i, bridge_pwm_i, comm_start_i, bemf_falling_i, zc_cmp_i} = 6'h00;
    comm_state_i = 3'h0;
    dead_time_count_i = 6'h02;
    recirc_mode_sel_i = 2'b10;
    cyc(4);
    arst_n_i = 1'b1;
    cyc(1);
    chk("reset low gates", 3'h0, lo);
    chk("reset high gates", 3'h7, hn);
    drive_en_i = 1'b1;
    bridge_pwm_i = 1'b1;
    cyc(30);
    chk("on low gates", 3'h2, lo);
    chk("on high gates", 3'h6, hn);
    chk("on phase nodes", 2'b01, sense[1:0]);
    comm_sweep();
    foreach (dts[i])
      dead(dts[i]);
    dead_time_count_i = 6'h02;
    offtime(2'b01, 1'b1);
    offtime(2'b11, 1'b0);
    offtime(2'b10, 1'b0);
    zc(1'b1);
    zc(1'b0);
    drive_en_i = 1'b0;
    cyc(3);
    chk("disabled gates", 3'h7, hn & ~lo);
    chk("shoot through", 1'b0, shoot);
    results();
  end

  // whole run is about 1400 cycles, so 60 us is ample
  initial
  begin
    #60us;
    fail_count++;
    $display("MISMATCH watchdog expected done seen hang");
    results();
  end
endmodule
